// ==== pkg/trig_route_regs.svh ====
// Register offsets, field positions and reset values for the trigger router
`ifndef TRIG_ROUTE_REGS_SVH
`define TRIG_ROUTE_REGS_SVH

`define CTRL_A_OFS 12'h000
`define CTRL_B_OFS 12'h004
`define SWREQ_OFS 12'h008
`define STATUS_OFS 12'h00C

`define SRC_LSB 0
`define SRC_MSB 1
`define USER_IDX_BIT 2
`define POL_BIT 4
`define DIR_BIT 8

`define SRC_RST 2'h0
`define POL_RST 1'h0
`define DIR_RST 1'h0
`define USER_IDX_RST 1'h0

`define SWREQ_U1_BIT 0
`define SWREQ_U2_BIT 1

`endif

// ==== pkg/trig_route_pkg.sv ====
// Types for the trigger router
package trig_route_pkg;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_PORT_A,
        SRC_PORT_B,
        SRC_USER
    } src_sel_t;

    typedef struct packed {
        logic dir_out;
        logic falling;
        logic user_idx;
        src_sel_t src;
    } port_cfg_t;

endpackage

// ==== verilog/trig_port_drive.sv ====
// One trigger connector output stage
`timescale 1ns/1ps
`include "trig_route_regs.svh"

module trig_port_drive (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire trig_route_pkg::port_cfg_t cfg,
    // Trigger sources
    input wire logic in_a,
    input wire logic in_b,
    input wire logic [1:0] user_pulse,
    // Pin
    output logic pin_o,
    output logic pin_oe
);

    wire logic routed;
    wire logic user_sel;
    wire logic driven;

    assign user_sel = cfg.user_idx ? user_pulse[1] : user_pulse[0];
    assign routed = (cfg.src == trig_route_pkg::SRC_PORT_A) ? in_a :
                    (cfg.src == trig_route_pkg::SRC_PORT_B) ? in_b :
                    (cfg.src == trig_route_pkg::SRC_USER) ? user_sel :
                    1'b0;
    assign driven = cfg.dir_out && (cfg.src != trig_route_pkg::SRC_NONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o <= routed ^ cfg.falling;
            pin_oe <= driven;
        end
    end

endmodule

// ==== verilog/trigger_output_router.sv ====
// Trigger output router with APB registers
`timescale 1ns/1ps
`include "trig_route_regs.svh"

module trigger_output_router (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // First trigger port pin
    input wire logic first_trigger_port_i,
    output logic first_trigger_port_o,
    output logic first_trigger_port_oe,
    // Second trigger port pin
    input wire logic second_trigger_port_i,
    output logic second_trigger_port_o,
    output logic second_trigger_port_oe
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync_a_r;
    logic [2:0] sync_b_r;
    logic in_a_r;
    logic in_b_r;

    // Three stages per pin
    wire logic [2:0] sync_a_nxt = {sync_a_r[1:0], first_trigger_port_i};
    wire logic [2:0] sync_b_nxt = {sync_b_r[1:0], second_trigger_port_i};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
        end else begin
            sync_a_r <= sync_a_nxt;
            sync_b_r <= sync_b_nxt;
        end
    end

    // Settled once second and third stages agree
    function automatic logic settled(input logic [2:0] s);
        return s[1] == s[2];
    endfunction

    // Inputs taken as received, polarity not applied
    wire logic in_a_nxt = settled(sync_a_r) ? sync_a_r[2] : in_a_r;
    wire logic in_b_nxt = settled(sync_b_r) ? sync_b_r[2] : in_b_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_a_r <= 1'b0;
            in_b_r <= 1'b0;
        end else begin
            in_a_r <= in_a_nxt;
            in_b_r <= in_b_nxt;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    trig_route_pkg::port_cfg_t cfg_a_r;
    trig_route_pkg::port_cfg_t cfg_b_r;
    logic [1:0] user_pulse_r;

    wire logic acc = psel && penable && pready;
    wire logic wr = acc && pwrite && pstrb[0];
    wire logic hit_a = (paddr == `CTRL_A_OFS);
    wire logic hit_b = (paddr == `CTRL_B_OFS);
    wire logic hit_req = (paddr == `SWREQ_OFS);
    wire logic hit_st = (paddr == `STATUS_OFS);
    wire logic mapped = hit_a || hit_b || hit_req || hit_st;

    // Write strobes per register
    wire logic wr_a = wr && hit_a;
    wire logic wr_b = wr && hit_b;
    wire logic wr_req = wr && hit_req;

    function automatic trig_route_pkg::port_cfg_t cfg_from(input logic [31:0] d);
        trig_route_pkg::port_cfg_t c;
        c.src = trig_route_pkg::src_sel_t'(d[`SRC_MSB:`SRC_LSB]);
        c.user_idx = d[`USER_IDX_BIT];
        c.falling = d[`POL_BIT];
        c.dir_out = d[`DIR_BIT];
        return c;
    endfunction

    function automatic logic [31:0] cfg_to(input trig_route_pkg::port_cfg_t c);
        logic [31:0] d;
        d = 32'h0000_0000;
        d[`SRC_MSB:`SRC_LSB] = c.src;
        d[`USER_IDX_BIT] = c.user_idx;
        d[`POL_BIT] = c.falling;
        d[`DIR_BIT] = c.dir_out;
        return d;
    endfunction

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Status: enables, then received levels
    wire logic [3:0] status_bits = {in_b_r, in_a_r, second_trigger_port_oe, first_trigger_port_oe};
    wire logic [31:0] status_word = {28'h0000000, status_bits};
    wire logic [31:0] rd_word = hit_a ? cfg_to(cfg_a_r) :
                                hit_b ? cfg_to(cfg_b_r) :
                                hit_st ? status_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    trig_route_pkg::port_cfg_t cfg_a_nxt;
    trig_route_pkg::port_cfg_t cfg_b_nxt;
    logic [1:0] user_pulse_nxt;
    logic pready_nxt;
    logic pslverr_nxt;
    logic [31:0] prdata_nxt;

    assign cfg_a_nxt = wr_a ? cfg_from(pwdata) : cfg_a_r;
    assign cfg_b_nxt = wr_b ? cfg_from(pwdata) : cfg_b_r;
    assign user_pulse_nxt = wr_req ? pwdata[`SWREQ_U2_BIT:`SWREQ_U1_BIT] : 2'h0;
    // Ready one cycle after setup, no wait states
    assign pready_nxt = psel && !pready;
    assign pslverr_nxt = psel && !pready && !mapped;
    assign prdata_nxt = (psel && !pwrite) ? rd_word : 32'h0000_0000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // First connector settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_a_r <= '{dir_out: `DIR_RST, falling: `POL_RST, user_idx: `USER_IDX_RST,
                         src: trig_route_pkg::SRC_NONE};
        end else begin
            cfg_a_r <= cfg_a_nxt;
        end
    end

    // Second connector settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_b_r <= '{dir_out: `DIR_RST, falling: `POL_RST, user_idx: `USER_IDX_RST,
                         src: trig_route_pkg::SRC_NONE};
        end else begin
            cfg_b_r <= cfg_b_nxt;
        end
    end

    // One-cycle user trigger pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_pulse_r <= 2'h0;
        end else begin
            user_pulse_r <= user_pulse_nxt;
        end
    end

    // Bus handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // Read data, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Connector stages
    // ------------------------------------------------------------
    trig_port_drive u_port_a (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_a_r),
        .in_a(in_a_r),
        .in_b(in_b_r),
        .user_pulse(user_pulse_r),
        .pin_o(first_trigger_port_o),
        .pin_oe(first_trigger_port_oe)
    );

    trig_port_drive u_port_b (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_b_r),
        .in_a(in_a_r),
        .in_b(in_b_r),
        .user_pulse(user_pulse_r),
        .pin_o(second_trigger_port_o),
        .pin_oe(second_trigger_port_oe)
    );

endmodule

// ==== dv/trigger_output_router_asserts.sv ====
// Port checks for the trigger router
`timescale 1ns/1ps
module trigger_output_router_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pin enables
    input wire logic first_trigger_port_oe,
    input wire logic second_trigger_port_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    // ----------
    // Checks
    // ----------
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held");
    chk_ready_idle: assert property (!psel |=> !pready)
        else $error("ready while idle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_err_unmapped: assert property (acc && paddr > 12'h00C |-> pslverr)
        else $error("unmapped not refused");
    chk_err_mapped: assert property (acc && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped refused");
    chk_swreq_reads_zero: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata == 32'h0)
        else $error("request reads nonzero");
    chk_oe_a_hold: assert property (!psel [*4] |-> $stable(first_trigger_port_oe))
        else $error("enable A moved");
    chk_oe_b_hold: assert property (!psel [*4] |-> $stable(second_trigger_port_oe))
        else $error("enable B moved");
    cov_refused: cover property (acc && pslverr);
    cov_drive_a: cover property ($rose(first_trigger_port_oe));
    cov_drive_b: cover property ($rose(second_trigger_port_oe));
endmodule

// ==== dv/trig_equipment.sv ====
// External test equipment on both connectors
`timescale 1ns/1ps
module trig_equipment (
    // Equipment levels
    input wire logic ext_a,
    input wire logic ext_b,
    // Device pins
    input wire logic a_o,
    input wire logic a_oe,
    input wire logic b_o,
    input wire logic b_oe,
    // Connector levels
    output logic wire_a,
    output logic wire_b
);
    // Equipment backs off while the device drives
    assign wire_a = a_oe ? a_o : ext_a;
    assign wire_b = b_oe ? b_o : ext_b;
endmodule

// ==== dv/test_trigger_output_router.sv ====
// Bench for the trigger router
`timescale 1ns/1ps
module test_trigger_output_router;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ext_a = 0, ext_b = 0, wire_a, wire_b, a_o, a_oe, b_o, b_oe;
    int bad_count = 0, checked = 0;
    logic [31:0] hi_a, lo_b;
    always #2 pclk = ~pclk;
    trigger_output_router dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .first_trigger_port_i(wire_a), .first_trigger_port_o(a_o),
        .first_trigger_port_oe(a_oe), .second_trigger_port_i(wire_b), .second_trigger_port_o(b_o),
        .second_trigger_port_oe(b_oe));
    trig_equipment eq (.ext_a, .ext_b, .a_o, .a_oe, .b_o, .b_oe, .wire_a, .wire_b);
    task end_of_test;
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // ----------
    // Tests
    // ----------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'h101);
        pstrb <= 4'hF;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, i[2] ? 12'h000 : 12'h004, 32'h0);
            apb(1'b1, i[2] ? 12'h004 : 12'h000, {23'h0, 1'b1, 3'h0, i[0], 2'h0, i[2] ? 2'h1 : 2'h2});
            ext_a <= i[1]; ext_b <= i[1];
            repeat (8) @(posedge pclk);
            chk(i[2] ? wire_b : wire_a, i[1] ^ i[0]);
        end
        apb(1'b1, 12'h000, 32'h103);
        apb(1'b1, 12'h004, 32'h117);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, 12'h008, 32'h1 << j);
            hi_a = 0; lo_b = 0;
            repeat (6) begin @(posedge pclk); hi_a += wire_a; lo_b += !wire_b; end
            chk(hi_a, j == 0);
            chk(lo_b, j == 1);
        end
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h012);
        apb(1'b1, 12'h004, 32'h100);
        ext_a <= 1'b1; ext_b <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd[3:0], 4'h4);
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        end_of_test;
    end
endmodule
bind trigger_output_router trigger_output_router_asserts chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .first_trigger_port_oe, .second_trigger_port_oe);
